/* File: hdl/spg_top.sv */
// module: stepper excitation pattern channel driven by timer matches
`timescale 1ns/1ps
// Function
// - pattern and readback change only on a write or on rising edge of selected trigger, hold otherwise
// - direction bit 0 rotates phase 0 toward 3; 1 rotates backwards
// - single and two-step modes ignore the alternate nibble
// - 1-2 step ring order b7 b3 b6 b2 b5 b1 b4 b0
// - in 1-2 step, output and alternate nibbles shift together
// - 8-bit mode triggers on match with register selected by source select
// - 16-bit mode triggers when counter equals b*256 plus a
// - programmable pulse mode triggers only on match with register b
// - PWM mode produces no trigger
// - 8-bit timer triggers pass only while invert enable is set
// - channel one on 16-bit timer triggers on counter four or five matches
// - timer four trigger needs enable a or b and match with register f
// - timer five trigger needs enable c and match with register h
// - phase bits reach pins only with pins output and pattern function
module spg_top (
    input  wire logic                            CLOCK,        // 100 MHz system clock
    input  wire logic                            RST,          // synchronous reset, active high
    input  wire spg_pkg::spg_cfg_t               CFG,          // channel configuration
    input  wire logic                            LOAD,         // write pattern_output_reg
    input  wire logic [7:0]                      LOAD_DATA,    // pattern nibble high, alternate low
    input  wire logic [spg_pkg::CNT_W-1:0]       UC_LO,        // 8-bit up counter (low in 16-bit)
    input  wire logic [spg_pkg::CNT_W-1:0]       UC_HI,        // upper up counter in 16-bit mode
    input  wire logic [spg_pkg::CNT_W-1:0]       MATCH_A,      // match_reg_a
    input  wire logic [spg_pkg::CNT_W-1:0]       MATCH_B,      // match_reg_b
    input  wire logic [spg_pkg::CNT16_W-1:0]     UC_FOUR,      // up_counter_four
    input  wire logic [spg_pkg::CNT16_W-1:0]     MATCH_F,      // match_reg_f
    input  wire logic [spg_pkg::CNT16_W-1:0]     UC_FIVE,      // up_counter_five
    input  wire logic [spg_pkg::CNT16_W-1:0]     MATCH_H,      // match_reg_h
    output logic      [3:0]                      PHASE_OUT,    // pattern to port pins
    output logic      [3:0]                      PHASE_OE,     // per-pin output enable
    output logic      [7:0]                      PATTERN_RD,   // readback: pattern and alternate
    output logic                                 SHIFT_PULSE   // one-cycle shift strobe
);

    // ****************************************
    // trigger selection
    // ****************************************
    logic       trig8;
    logic       trig16_4;
    logic       trig16_5;
    logic       trig;
    logic [7:0] ring;
    logic [7:0] ring_nxt;

    always_comb begin
        unique case (CFG.tmode)
            spg_pkg::SPG_TM_8BIT:  trig8 = CFG.ff_src_sel ? (UC_LO == MATCH_B)
                                                          : (UC_LO == MATCH_A);
            spg_pkg::SPG_TM_16BIT: trig8 = ({UC_HI, UC_LO} == {MATCH_B, MATCH_A});
            spg_pkg::SPG_TM_PPG:   trig8 = (UC_LO == MATCH_B);
            spg_pkg::SPG_TM_PWM:   trig8 = 1'b0;
        endcase
    end

    assign trig16_4 = (CFG.cte_a | CFG.cte_b) & (UC_FOUR == MATCH_F);
    assign trig16_5 = CFG.cte_c & (UC_FIVE == MATCH_H);

    always_comb begin
        unique case (CFG.src)
            spg_pkg::SPG_SRC_TMR8: trig = trig8 & CFG.ff_inv_en;
            spg_pkg::SPG_SRC_TMR4: trig = trig16_4;
            spg_pkg::SPG_SRC_TMR5: trig = trig16_5;
            default:               trig = 1'b0;
        endcase
    end

    // ****************************************
    // helpers
    // ****************************************
    // one place along the nibble; forward carries phase 3 round to phase 0
    function automatic logic [3:0] rot4(
        input logic [3:0] v,     // nibble to move
        input logic       rev    // reverse_direction_bit
    );
        if (rev) begin
            return {v[0], v[3:1]};
        end
        return {v[2:0], v[3]};
    endfunction

    // pattern bits take the odd ring places, alternate bits the even ones
    function automatic logic [7:0] weave(
        input logic [3:0] p,     // pattern nibble
        input logic [3:0] a      // alternate nibble
    );
        return {p[3], a[3], p[2], a[2], p[1], a[1], p[0], a[0]};
    endfunction

    // ****************************************
    // pattern state
    // ****************************************
    spg_pkg::spg_state_t st_ff;
    spg_pkg::spg_state_t nxt_st;
    logic                rise;

    // match is a level while the counter sits on it; only its first cycle steps
    assign rise = trig & ~st_ff.trig_d;

    // ring order b7 b3 b6 b2 b5 b1 b4 b0
    assign ring = weave(st_ff.pat, st_ff.alt);
    // normal rotation moves toward phase 3, i.e. toward higher ring bits
    assign ring_nxt = CFG.reverse ? {ring[0], ring[7:1]} : {ring[6:0], ring[7]};

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.trig_d = trig;
        if (LOAD) begin
            nxt_st.pat = LOAD_DATA[7:4];
            nxt_st.alt = LOAD_DATA[3:0];
        end else if (rise) begin
            if (CFG.step_half) begin
                nxt_st.pat = {ring_nxt[7], ring_nxt[5], ring_nxt[3], ring_nxt[1]};
                nxt_st.alt = {ring_nxt[6], ring_nxt[4], ring_nxt[2], ring_nxt[0]};
            end else begin
                // alternate nibble left untouched and unused
                nxt_st.pat = rot4(st_ff.pat, CFG.reverse);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_ff <= '{pat: spg_pkg::PAT_RST, alt: spg_pkg::ALT_RST, trig_d: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic pins_on;
    assign pins_on     = CFG.port_out & CFG.port_func;
    assign PHASE_OUT   = pins_on ? st_ff.pat : 4'h0;
    assign PHASE_OE    = {4{pins_on}};
    assign PATTERN_RD  = {st_ff.pat, st_ff.alt};
    assign SHIFT_PULSE = rise & ~LOAD;

    // ****************************************
    // assertions: trigger decoding
    // ****************************************
    // a step needs a fresh match: history low and no write in the way
    a_eight_a: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_8BIT && CFG.ff_inv_en
         && !CFG.ff_src_sel && UC_LO == MATCH_A && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("8-bit match a did not step");

    a_eight_b: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_8BIT && CFG.ff_inv_en
         && CFG.ff_src_sel && UC_LO == MATCH_B && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("8-bit match b did not step");

    a_eight_off: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_8BIT
         && !CFG.ff_src_sel && UC_LO != MATCH_A) |-> !SHIFT_PULSE)
        else $error("8-bit shift off selected match");

    a_wide_step: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_16BIT && CFG.ff_inv_en
         && {UC_HI, UC_LO} == {MATCH_B, MATCH_A} && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("16-bit match did not step");

    a_wide_partial: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_16BIT
         && UC_HI != MATCH_B) |-> !SHIFT_PULSE)
        else $error("16-bit shift on half match");

    a_ppg_step: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_PPG && CFG.ff_inv_en
         && UC_LO == MATCH_B && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("ppg period match did not step");

    a_ppg_match: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_PPG && UC_LO != MATCH_B)
        |-> !SHIFT_PULSE)
        else $error("ppg shift off period match");

    a_pwm_none: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && CFG.tmode == spg_pkg::SPG_TM_PWM) |-> !SHIFT_PULSE)
        else $error("shift in pwm mode");

    a_inv_gate: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR8 && !CFG.ff_inv_en) |-> !SHIFT_PULSE)
        else $error("shift without invert enable");

    a_t4_step: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR4 && (CFG.cte_a || CFG.cte_b) && UC_FOUR == MATCH_F
         && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("timer four match did not step");

    a_t4_gate: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR4 && !CFG.cte_a && !CFG.cte_b) |-> !SHIFT_PULSE)
        else $error("timer four shift without enable");

    a_t4_off: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR4 && UC_FOUR != MATCH_F) |-> !SHIFT_PULSE)
        else $error("timer four shift off match");

    a_t5_step: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR5 && CFG.cte_c && UC_FIVE == MATCH_H
         && !st_ff.trig_d && !LOAD) |-> SHIFT_PULSE)
        else $error("timer five match did not step");

    a_t5_gate: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR5 && !CFG.cte_c) |-> !SHIFT_PULSE)
        else $error("timer five shift without enable");

    a_t5_off: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::SPG_SRC_TMR5 && UC_FIVE != MATCH_H) |-> !SHIFT_PULSE)
        else $error("timer five shift off match");

    a_src_none: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.src == spg_pkg::spg_src_t'(2'h3)) |-> !SHIFT_PULSE)
        else $error("shift from unused source code");

    // ****************************************
    // assertions: pattern movement
    // ****************************************
    a_hold_between: assert property (@(posedge CLOCK) disable iff (RST)
        (!$past(rise) && !$past(LOAD)) |-> $stable(st_ff.pat))
        else $error("pattern changed without trigger");

    a_load_wins: assert property (@(posedge CLOCK) disable iff (RST)
        LOAD |-> (!SHIFT_PULSE ##1 PATTERN_RD == $past(LOAD_DATA)))
        else $error("write lost or trigger taken with write");

    a_single_step: assert property (@(posedge CLOCK) disable iff (RST)
        SHIFT_PULSE |=> !SHIFT_PULSE)
        else $error("held trigger stepped twice");

    a_fwd_rotate: assert property (@(posedge CLOCK) disable iff (RST)
        (rise && !LOAD && !CFG.reverse && !CFG.step_half) |=>
        st_ff.pat == {$past(st_ff.pat[2:0]), $past(st_ff.pat[3])})
        else $error("forward rotation wrong");

    a_rev_rotate: assert property (@(posedge CLOCK) disable iff (RST)
        (rise && !LOAD && CFG.reverse && !CFG.step_half) |=>
        st_ff.pat == {$past(st_ff.pat[0]), $past(st_ff.pat[3:1])})
        else $error("reverse rotation wrong");

    a_alt_ignored: assert property (@(posedge CLOCK) disable iff (RST)
        (!LOAD && !CFG.step_half) |=> $stable(st_ff.alt))
        else $error("alternate changed in full-step mode");

    a_half_ones: assert property (@(posedge CLOCK) disable iff (RST)
        (rise && !LOAD && CFG.step_half) |=>
        $countones({st_ff.pat, st_ff.alt}) == $past($countones({st_ff.pat, st_ff.alt})))
        else $error("ring lost bits");

    // forward: new pattern is the old alternate, alternate takes the pattern moved one up
    a_half_fwd: assert property (@(posedge CLOCK) disable iff (RST)
        (rise && !LOAD && CFG.step_half && !CFG.reverse) |=>
        PATTERN_RD == {$past(st_ff.alt), $past(st_ff.pat[2:0]), $past(st_ff.pat[3])})
        else $error("forward half step wrong");

    a_half_rev: assert property (@(posedge CLOCK) disable iff (RST)
        (rise && !LOAD && CFG.step_half && CFG.reverse) |=>
        PATTERN_RD == {$past(st_ff.alt[0]), $past(st_ff.alt[3:1]), $past(st_ff.pat)})
        else $error("reverse half step wrong");

    // ****************************************
    // assertions: pins and reset
    // ****************************************
    a_pins_off: assert property (@(posedge CLOCK) disable iff (RST)
        !(CFG.port_out && CFG.port_func) |-> (PHASE_OE == 4'h0 && PHASE_OUT == 4'h0))
        else $error("pins driven while not assigned");

    a_pins_on: assert property (@(posedge CLOCK) disable iff (RST)
        (CFG.port_out && CFG.port_func) |-> (PHASE_OE == 4'hF && PHASE_OUT == st_ff.pat))
        else $error("assigned pins not showing pattern");

    a_oe_shape: assert property (@(posedge CLOCK) disable iff (RST)
        (PHASE_OE == 4'h0 || PHASE_OE == 4'hF))
        else $error("pin enables split");

    a_reset_clear: assert property (@(posedge CLOCK)
        RST |=> PATTERN_RD == 8'h00)
        else $error("reset left pattern set");

    c_fwd_step: cover property (@(posedge CLOCK) disable iff (RST) rise && !CFG.reverse);
    c_rev_step: cover property (@(posedge CLOCK) disable iff (RST) rise && CFG.reverse);
    c_half_step: cover property (@(posedge CLOCK) disable iff (RST) rise && CFG.step_half);
    c_t4_step: cover property (@(posedge CLOCK) disable iff (RST) rise && CFG.src == spg_pkg::SPG_SRC_TMR4);
    c_t5_step: cover property (@(posedge CLOCK) disable iff (RST) rise && CFG.src == spg_pkg::SPG_SRC_TMR5);

endmodule

/* File: hdl/spg_pkg.sv */
// package: shared constants and types for the stepper pattern generator
package spg_pkg;

    // ****************************************
    // timer modes and trigger sources
    // ****************************************
    typedef enum logic [1:0] {
        SPG_TM_8BIT,
        SPG_TM_16BIT,
        SPG_TM_PPG,
        SPG_TM_PWM
    } spg_tmode_t;

    typedef enum logic [1:0] {
        SPG_SRC_TMR8,
        SPG_SRC_TMR4,
        SPG_SRC_TMR5
    } spg_src_t;

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam logic [3:0] PAT_RST = 4'h0;
    localparam logic [3:0] ALT_RST = 4'h0;
    localparam int         CNT_W   = 8;
    localparam int         CNT16_W = 16;

    // configuration bundle from software
    typedef struct packed {
        logic       step_half;       // 1-2 step excitation
        logic       reverse;         // reverse_direction_bit
        logic       ff_src_sel;      // flipflop_source_select
        logic       ff_inv_en;       // flipflop_invert_enable
        logic       cte_a;           // compare_trigger_enable_a
        logic       cte_b;           // compare_trigger_enable_b
        logic       cte_c;           // compare_trigger_enable_c
        logic       port_out;        // port pins 0..3 set as outputs
        logic       port_func;       // port pins 0..3 in pattern function
        spg_tmode_t tmode;
        spg_src_t   src;
    } spg_cfg_t;

    // all module state
    typedef struct packed {
        logic [3:0] pat;
        logic [3:0] alt;
        logic       trig_d;
    } spg_state_t;

endpackage

/* File: testbench/spg_motor_model.sv */
// partner model: motor driver inputs on the shared port pins
`timescale 1ns/1ps
module spg_motor_model (
    input  wire logic [3:0] PHASE,  // phase lines from the channel
    input  wire logic [3:0] OE,     // per-pin drive enable
    output logic      [3:0] pins    // level seen at the driver inputs
);
    // undriven pins are pulled down on the driver board, so stale data never shows
    assign pins = PHASE & OE;
endmodule

/* File: testbench/stepper_pattern_generator_test.sv */
// testbench: stepper pattern channel checked against a ring model
`timescale 1ns/1ps
module stepper_pattern_generator_test;
    logic              CLOCK = 1'b0;
    logic              RST   = 1'b1;
    logic              LOAD  = 1'b0;
    spg_pkg::spg_cfg_t cfg   = '0;
    logic [7:0]        ld    = 8'h00;
    logic [7:0]        ma, mb, ul, uh, rd, e, m;
    logic [15:0]       mf, mh, u4, u5;
    logic [3:0]        ph, oe, pins;
    logic              sp;
    logic [7:0]        q[$];
    logic [7:0]        pats[4] = '{8'h1A, 8'h35, 8'hC8, 8'h37};
    int                mismatches = 0;
    int                num_checks = 0;

    always #5 CLOCK = ~CLOCK;

    spg_top dut_u (.CLOCK(CLOCK), .RST(RST), .CFG(cfg), .LOAD(LOAD), .LOAD_DATA(ld), .UC_LO(ul), .UC_HI(uh),
        .MATCH_A(ma), .MATCH_B(mb), .UC_FOUR(u4), .MATCH_F(mf), .UC_FIVE(u5), .MATCH_H(mh),
        .PHASE_OUT(ph), .PHASE_OE(oe), .PATTERN_RD(rd), .SHIFT_PULSE(sp));
    spg_motor_model motor_u (.PHASE(ph), .OE(oe), .pins(pins));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] nxt(input logic [7:0] v);
        logic [3:0] p;
        logic [3:0] a;
        p = v[7:4];
        a = v[3:0];
        if (cfg.step_half)
            return cfg.reverse ? {a[0], a[3:1], p} : {a, p[2:0], p[3]};
        return {cfg.reverse ? {p[0], p[3:1]} : {p[2:0], p[3]}, a};
    endfunction

    // counters parked off their compare values between triggers, except upper counter held on match b
    task automatic idle;
        ul <= ma ^ 8'hF0;
        uh <= mb;
        u4 <= ~mf;
        u5 <= ~mh;
    endtask

    task automatic hit(input int k);
        if (k == 0) ul <= ma;
        if (k == 1) ul <= mb;
        if (k == 2) u4 <= mf;
        if (k == 3) u5 <= mh;
    endtask

    task automatic fire(input int k, input bit st);
        @(posedge CLOCK);
        hit(k);
        if (st) begin
            m = nxt(m);
            q.push_back(m);
        end
        @(posedge CLOCK);
        idle();
        repeat (2) @(posedge CLOCK);
    endtask

    // trigger raised in the load cycle must be lost
    task automatic load(input logic [7:0] v, input int k);
        @(posedge CLOCK);
        LOAD <= 1'b1;
        ld <= v;
        hit(k);
        m = v;
        q.push_back(v);
        @(posedge CLOCK);
        LOAD <= 1'b0;
        idle();
    endtask

    // c = {tmode[1:0], src[1:0], src_sel, inv_en, cte_a, cte_b, cte_c}
    task automatic run(input logic [8:0] c, input int k, input bit st);
        @(posedge CLOCK);
        cfg.tmode <= spg_pkg::spg_tmode_t'(c[8:7]);
        cfg.src <= spg_pkg::spg_src_t'(c[6:5]);
        {cfg.ff_src_sel, cfg.ff_inv_en, cfg.cte_a, cfg.cte_b, cfg.cte_c} <= c[4:0];
        {cfg.port_out, cfg.port_func} <= 2'($urandom);
        fire(k, st);
    endtask

    always @(posedge CLOCK) begin
        if (!RST && (sp === 1'b1 || LOAD === 1'b1)) begin
            #1;
            if (q.size() == 0) begin
                cmp(8'h01, 8'h00);
            end else begin
                e = q.pop_front();
                cmp(rd, e);
                cmp({oe, pins}, (cfg.port_out & cfg.port_func) ? {4'hF, e[7:4]} : 8'h00);
            end
        end
    end

    initial begin
        #100_000;
        mismatches++;
        close_out();
    end

    initial begin
        void'($urandom(32'h7460));
        ma = 8'($urandom);
        mb = ma ^ 8'h0F;
        mf = 16'($urandom);
        mh = 16'($urandom);
        idle();
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        cfg.ff_inv_en <= 1'b1;
        {cfg.port_out, cfg.port_func} <= 2'h3;
        @(posedge CLOCK);
        #1;
        cmp(rd, 8'h00);
        foreach (pats[i])
            for (int d = 0; d < 2; d++) begin
                @(posedge CLOCK);
                cfg.step_half <= (i > 1);
                cfg.reverse <= d[0];
                load(pats[i], -1);
                repeat ((i > 1) ? 8 : 4) fire(0, 1);
            end
        @(posedge CLOCK);
        cfg.step_half <= 1'b0;
        cfg.reverse <= 1'b0;
        load(8'h35, 0);
        run(9'h008, 0, 1);
        run(9'h008, 1, 0);
        run(9'h018, 1, 1);
        run(9'h000, 0, 0);
        run(9'h088, 0, 1);
        run(9'h080, 0, 0);
        run(9'h108, 1, 1);
        run(9'h108, 0, 0);
        run(9'h188, 0, 0);
        run(9'h198, 1, 0);
        run(9'h0A4, 2, 1);
        run(9'h022, 2, 1);
        run(9'h021, 2, 0);
        run(9'h026, 3, 0);
        run(9'h041, 3, 1);
        run(9'h046, 3, 0);
        repeat (3) @(posedge CLOCK);
        if (q.size() != 0) cmp(8'h00, 8'h01);
        close_out();
    end
endmodule
